// ---- hw/memory_space_address_decode_defines.svh ----
// Constants for the memory space address decode block
`ifndef MEMORY_SPACE_ADDRESS_DECODE_DEFINES_SVH
`define MEMORY_SPACE_ADDRESS_DECODE_DEFINES_SVH
`define PROG_RESET_ADDR 24'h000000
`define PROG_GOTO_TARGET_ADDR 24'h000002
`define PROG_IVT_PRIMARY_LO 24'h000004
`define PROG_IVT_PRIMARY_HI 24'h0000ff
`define PROG_IVT_ALT_LO 24'h000100
`define PROG_IVT_ALT_HI 24'h0001ff
`define PROG_VECTOR_END 24'h000200
`define PROG_CFG_WORD1_ADDR 24'h00abfc
`define PROG_CFG_WORD2_ADDR 24'h00abfe
`define PROG_STEP 24'h000002
`define DATA_IMPL_LIMIT 16'h2000
`define DATA_SFR_LIMIT 16'h0800
`define DATA_NEAR_LIMIT 16'h2000
`define DATA_WINDOW_BIT 15
`define CPU_CTRL_WINDOW_BIT 2
`define STEP_BYTE 16'h0001
`define STEP_WORD 16'h0002
`define CFG_RESET_VALUE 24'hffffff
`endif

// ---- hw/memory_space_pkg.sv ----
// Types shared by the memory space address decode block
package memory_space_pkg;
  // Program word: only 24 of the 32 bits of the lower/upper pair exist
  typedef logic [23:0] prog_word_t;
  // Data side access request from the core
  typedef struct packed {
    logic valid;
    logic is_byte;
    logic [15:0] addr;
  } data_req_s;
  typedef enum logic [1:0] {
    CFG_IDLE = 2'b00,
    CFG_WORD1 = 2'b01,
    CFG_WORD2 = 2'b10,
    CFG_DONE = 2'b11
  } cfg_state_e;
endpackage : memory_space_pkg

// ---- hw/data_lane_unit.sv ----
// Byte lane steering for data reads and writes
`timescale 1ns/100ps
`default_nettype none
module data_lane_unit (
  input wire logic is_byte,
  input wire logic addr_lsb,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] mem_word,
  output logic [15:0] rd_data,
  output logic [15:0] mem_wdata,
  output logic [1:0] lane_strobe
);
  ////////////////////////////////////////////////////////////////////////
  // Read lane select and write lane strobes
  always_comb begin
    if (is_byte) begin
      // Selected byte lands on the low lane
      rd_data = {8'h00, addr_lsb ? mem_word[15:8] : mem_word[7:0]};
      mem_wdata = {wr_data[7:0], wr_data[7:0]};
      lane_strobe = addr_lsb ? 2'h2 : 2'h1;
    end else begin
      // LSB at even, MSB at odd
      rd_data = mem_word;
      mem_wdata = wr_data;
      lane_strobe = 2'h3;
    end
  end
endmodule : data_lane_unit
`default_nettype wire

// ---- hw/memory_space_address_decode.sv ----
// Program and data space address decode for the 16-bit core
`timescale 1ns/100ps
`default_nettype none
`include "memory_space_address_decode_defines.svh"
// Overview of operation
// - Program addresses even, PC steps two
// - Program words 24 bits, top byte absent
// - Addresses below 0x200 hold vectors only
// - Reset starts at zero, goto target follows
// - Primary and alternate vector tables provided
// - Reset copies two top words to configuration
// - Sixteen bit byte addresses, 64K range
// - Bit 15 selects program window
// - Outside implemented 8K reads zero
// - Low byte even, high byte odd
// - Post increment adds one or two
// - Byte read selects lane, low lane out
// - Shared word decode, separate byte strobes
// - Odd word access raises address error
// - Misaligned read completes, write suppressed
// - Byte load keeps register high byte
// - Sign extend and zero extend operations
// - Near area reached by 13-bit field
// - Move direct uses full 16-bit address
// - Separate read and write address generators
// - Window active only when enable bit set
// - Unused special register space reads zero
module memory_space_address_decode (
  input wire logic clock,
  input wire logic rst,
  // Program fetch side
  input wire logic pc_advance,
  input wire logic pc_load,
  input wire logic [23:0] pc_load_addr,
  output logic [23:0] prog_addr,
  output logic prog_fetch_vector,
  input wire logic [31:0] prog_rdata,
  output logic [23:0] prog_instr,
  // Configuration load
  output logic cfg_busy,
  output logic [23:0] cfg_word1,
  output logic [23:0] cfg_word2,
  // Core control
  input wire logic [15:0] cpu_ctrl,
  input wire logic [15:0] sfr_present_map,
  // Read address generator
  input wire logic rd_valid,
  input wire logic rd_is_byte,
  input wire logic [15:0] rd_addr,
  input wire logic rd_direct,
  input wire logic rd_direct_near,
  input wire logic [12:0] rd_near_field,
  // Write address generator
  input wire logic wr_valid,
  input wire logic wr_is_byte,
  input wire logic [15:0] wr_addr,
  input wire logic [15:0] wr_data,
  // Post increment
  input wire logic [15:0] source_pointer_register,
  input wire logic post_inc_is_byte,
  output logic [15:0] source_pointer_next,
  // Memory array
  output logic [15:0] mem_rd_word_addr,
  input wire logic [15:0] mem_rd_word,
  output logic [15:0] mem_wr_word_addr,
  output logic [15:0] mem_wdata,
  output logic [1:0] mem_wr_strobe,
  // Program window
  output logic window_rd_req,
  output logic [14:0] window_rd_addr,
  input wire logic [15:0] window_rd_word,
  // Read data
  output logic [15:0] rd_data,
  // Working register load and extension
  input wire logic [15:0] wreg_old,
  input wire logic [15:0] wreg_src,
  input wire logic wreg_byte_load,
  input wire logic sign_extend_op,
  input wire logic zero_extend_op,
  output logic [15:0] wreg_new,
  // Trap
  output logic addr_error_trap,
  output logic addr_error_is_write
);

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    memory_space_pkg::cfg_state_e cfg_state;
    logic [23:0] pc;
    logic [23:0] cfg1;
    logic [23:0] cfg2;
    logic [15:0] rd_data;
    logic trap;
    logic trap_wr;
    logic [23:0] instr;
  } state_s;

  state_s state_ff; // Registered state
  state_s nxt_state; // Next state

  // Effective addresses after direct field selection
  logic [15:0] rd_byte_addr;
  logic rd_misaligned;
  logic wr_misaligned;
  logic rd_in_window;
  logic rd_implemented;
  logic [15:0] rd_lane_data;
  logic [15:0] lane_wdata;
  logic [1:0] lane_strobe;
  memory_space_pkg::data_req_s rd_req;

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  // Word access at an odd byte address
  function automatic logic odd_word(input logic is_byte,
                                    input logic [15:0] addr);
    odd_word = !is_byte && addr[0];
  endfunction : odd_word

  // Word index used by both byte lanes
  function automatic logic [15:0] word_of(input logic [15:0] addr);
    word_of = {addr[15:1], 1'b0};
  endfunction : word_of

  ////////////////////////////////////////////////////////////////////////
  // Read address generator decode
  always_comb begin
    // Near direct field zero-extends into 0x0000..0x1fff
    if (rd_direct && rd_direct_near) begin
      rd_byte_addr = {3'h0, rd_near_field};
    end else begin
      // Full 16-bit direct or indirect address
      rd_byte_addr = rd_addr;
    end
    rd_req = '{valid: rd_valid, is_byte: rd_is_byte, addr: rd_byte_addr};
  end

  assign rd_misaligned = rd_req.valid &&
                         odd_word(rd_req.is_byte, rd_byte_addr);
  assign wr_misaligned = wr_valid && odd_word(wr_is_byte, wr_addr);
  // Window only mapped while the control bit is set
  assign rd_in_window = rd_byte_addr[`DATA_WINDOW_BIT] &&
                        cpu_ctrl[`CPU_CTRL_WINDOW_BIT];
  assign rd_implemented = !rd_byte_addr[`DATA_WINDOW_BIT] &&
                          (rd_byte_addr < `DATA_IMPL_LIMIT);

  // Independent read and write address paths
  assign mem_rd_word_addr = word_of(rd_byte_addr);
  assign mem_wr_word_addr = word_of(wr_addr);
  assign window_rd_req = rd_req.valid && rd_in_window;
  assign window_rd_addr = rd_byte_addr[14:0];

  ////////////////////////////////////////////////////////////////////////
  // Lane steering, shared by source selection of read data
  data_lane_unit u_lanes (
    .is_byte(rd_req.is_byte),
    .addr_lsb(rd_byte_addr[0]),
    .wr_data(16'h0000),
    .mem_word(rd_in_window ? window_rd_word : mem_rd_word),
    .rd_data(rd_lane_data),
    .mem_wdata(),
    .lane_strobe()
  );

  // Write lanes steered on the write address
  data_lane_unit u_wr_lanes (
    .is_byte(wr_is_byte),
    .addr_lsb(wr_addr[0]),
    .wr_data(wr_data),
    .mem_word(16'h0000),
    .rd_data(),
    .mem_wdata(lane_wdata),
    .lane_strobe(lane_strobe)
  );

  assign mem_wdata = lane_wdata;
  // Misaligned write still runs but never reaches the array
  assign mem_wr_strobe = (wr_valid && !wr_misaligned) ? lane_strobe
                                                     : 2'h0;

  ////////////////////////////////////////////////////////////////////////
  // Post increment step
  assign source_pointer_next = source_pointer_register +
    (post_inc_is_byte ? `STEP_BYTE : `STEP_WORD);

  ////////////////////////////////////////////////////////////////////////
  // Working register byte load and extension
  always_comb begin
    if (sign_extend_op) begin
      wreg_new = {{8{wreg_src[7]}}, wreg_src[7:0]};
    end else if (zero_extend_op) begin
      wreg_new = {8'h00, wreg_src[7:0]};
    end else if (wreg_byte_load) begin
      // High byte kept as it was
      wreg_new = {wreg_old[15:8], wreg_src[7:0]};
    end else begin
      wreg_new = wreg_src;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic sfr_hole;
    sfr_hole = 1'b0;
    nxt_state = state_ff;
    // Unimplemented 128-byte special register block reads zero
    if (rd_byte_addr < `DATA_SFR_LIMIT) begin
      sfr_hole = !sfr_present_map[rd_byte_addr[10:7]];
    end
    // Configuration copy runs first after every reset
    unique case (state_ff.cfg_state)
      memory_space_pkg::CFG_IDLE: begin
        nxt_state.cfg_state = memory_space_pkg::CFG_WORD1;
      end
      memory_space_pkg::CFG_WORD1: begin
        nxt_state.cfg1 = prog_rdata[23:0];
        nxt_state.cfg_state = memory_space_pkg::CFG_WORD2;
      end
      memory_space_pkg::CFG_WORD2: begin
        nxt_state.cfg2 = prog_rdata[23:0];
        nxt_state.cfg_state = memory_space_pkg::CFG_DONE;
        nxt_state.pc = `PROG_RESET_ADDR;
      end
      memory_space_pkg::CFG_DONE: begin
        if (pc_load) begin
          // Low bit dropped keeps the PC on the lower word
          nxt_state.pc = {pc_load_addr[23:1], 1'b0};
        end else if (pc_advance) begin
          nxt_state.pc = state_ff.pc + `PROG_STEP;
        end
        // Upper byte of upper word is not implemented
        nxt_state.instr = prog_rdata[23:0];
      end
    endcase
    // Read data, zero outside implemented or mapped areas
    if (rd_req.valid && (rd_in_window || (rd_implemented && !sfr_hole))) begin
      nxt_state.rd_data = rd_lane_data;
    end else begin
      nxt_state.rd_data = 16'h0000;
    end
    // One cycle trap request, write has priority for direction
    nxt_state.trap = rd_misaligned || wr_misaligned;
    nxt_state.trap_wr = wr_misaligned;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= '{cfg_state: memory_space_pkg::CFG_IDLE,
                    pc: `PROG_RESET_ADDR,
                    cfg1: `CFG_RESET_VALUE,
                    cfg2: `CFG_RESET_VALUE,
                    rd_data: 16'h0000,
                    trap: 1'b0,
                    trap_wr: 1'b0,
                    instr: 24'h000000};
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb begin
    // Program bus shows config words during the copy
    unique case (state_ff.cfg_state)
      memory_space_pkg::CFG_WORD1: prog_addr = `PROG_CFG_WORD1_ADDR;
      memory_space_pkg::CFG_WORD2: prog_addr = `PROG_CFG_WORD2_ADDR;
      memory_space_pkg::CFG_IDLE,
      memory_space_pkg::CFG_DONE: prog_addr = state_ff.pc;
    endcase
  end
  // Fetches below 0x200 come from the vector area
  assign prog_fetch_vector = state_ff.pc < `PROG_VECTOR_END;
  assign prog_instr = state_ff.instr;
  assign cfg_busy = state_ff.cfg_state != memory_space_pkg::CFG_DONE;
  assign cfg_word1 = state_ff.cfg1;
  assign cfg_word2 = state_ff.cfg2;
  assign rd_data = state_ff.rd_data;
  assign addr_error_trap = state_ff.trap;
  assign addr_error_is_write = state_ff.trap_wr;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Odd word write raises a write-flavoured trap one cycle on
  a_odd_word_trap: assert property (@(posedge clock)
    disable iff (rst) (wr_valid && !wr_is_byte && wr_addr[0])
    |=> addr_error_trap && addr_error_is_write)
    else $error("odd word write no trap");
  // Odd word read traps too, near or full address alike
  a_odd_read_trap: assert property (@(posedge clock)
    disable iff (rst) (rd_valid && !rd_is_byte && rd_byte_addr[0])
    |=> addr_error_trap)
    else $error("odd word read no trap");
  // Misaligned write never strobes a lane
  a_write_suppressed: assert property (@(posedge clock)
    disable iff (rst) wr_misaligned |-> mem_wr_strobe == 2'h0)
    else $error("misaligned write reached array");
  // No trap without a misaligned request the cycle before
  a_trap_one_cycle: assert property (@(posedge clock)
    disable iff (rst)
    (addr_error_trap && !$past(rd_misaligned || wr_misaligned))
    |-> 1'b0)
    else $error("trap without cause");
  // Trap drops after one cycle unless a new fault arrives
  a_trap_pulse: assert property (@(posedge clock)
    disable iff (rst)
    (addr_error_trap && !rd_misaligned && !wr_misaligned)
    |=> !addr_error_trap)
    else $error("trap held too long");
  // Read-only fault reports a read direction
  a_trap_read_dir: assert property (@(posedge clock)
    disable iff (rst) (rd_misaligned && !wr_misaligned)
    |=> addr_error_trap && !addr_error_is_write)
    else $error("trap direction wrong");
  // Byte write strobes only the lane of address bit 0
  a_byte_strobe: assert property (@(posedge clock)
    disable iff (rst) (wr_valid && wr_is_byte)
    |-> mem_wr_strobe == (wr_addr[0] ? 2'h2 : 2'h1))
    else $error("wrong byte lane");
  // Lower half beyond the implemented area reads zero
  a_outside_zero: assert property (@(posedge clock)
    disable iff (rst)
    (rd_valid && !rd_byte_addr[15] && rd_byte_addr >= `DATA_IMPL_LIMIT)
    |=> rd_data == 16'h0000)
    else $error("outside read not zero");
  // Byte reads always come back on the low lane
  a_byte_low_lane: assert property (@(posedge clock)
    disable iff (rst) (rd_valid && rd_is_byte)
    |=> rd_data[15:8] == 8'h00)
    else $error("byte read upper lane not zero");
  // Window reads stay dark while the enable bit is clear
  a_window_gated: assert property (@(posedge clock)
    disable iff (rst) (rd_valid && rd_byte_addr[15] && !cpu_ctrl[2])
    |-> !window_rd_req ##1 rd_data == 16'h0000)
    else $error("window not gated");
  // Program counter moves by one word pair per step
  a_pc_step: assert property (@(posedge clock)
    disable iff (rst) (!cfg_busy && pc_advance && !pc_load)
    |=> prog_addr == $past(prog_addr) + 24'h000002)
    else $error("pc step wrong");
  // Both configuration words fetched in order, then address zero
  a_cfg_copy: assert property (@(posedge clock)
    $fell(rst) |-> ##1 prog_addr == `PROG_CFG_WORD1_ADDR ##1
      prog_addr == `PROG_CFG_WORD2_ADDR ##1 prog_addr == 24'h000000)
    else $error("config copy order wrong");
  // Pointer step is one for bytes and two for words
  a_post_inc: assert property (@(posedge clock)
    disable iff (rst) source_pointer_next - source_pointer_register ==
      (post_inc_is_byte ? 16'h0001 : 16'h0002))
    else $error("post increment wrong");
  // Byte load leaves the register's high byte alone
  a_byte_keeps_high: assert property (@(posedge clock)
    disable iff (rst)
    (wreg_byte_load && !sign_extend_op && !zero_extend_op)
    |-> wreg_new[15:8] == wreg_old[15:8])
    else $error("byte load touched high byte");
  // Sign extension copies bit 7 into the whole high byte
  a_sign_extend: assert property (@(posedge clock)
    disable iff (rst) sign_extend_op
    |-> wreg_new[15:8] == (wreg_src[7] ? 8'hff : 8'h00))
    else $error("sign extension wrong");
  // Main scenarios reached
  c_byte_write: cover property (@(posedge clock) wr_valid && wr_is_byte);
  c_trap_read: cover property (@(posedge clock)
    addr_error_trap && !addr_error_is_write);
  c_window_read: cover property (@(posedge clock) window_rd_req);
  c_cfg_done: cover property (@(posedge clock) $fell(cfg_busy));
  c_near_read: cover property (@(posedge clock)
    rd_valid && rd_direct && rd_direct_near);
endmodule : memory_space_address_decode
`default_nettype wire

// ---- testbench/mem_array_model.sv ----
// Memory arrays standing behind the address decode block
`timescale 1ns/100ps
`default_nettype none
module mem_array_model (
  input wire logic clock,
  input wire logic [23:0] prog_addr,
  output logic [31:0] prog_rdata,
  input wire logic [15:0] mem_rd_word_addr,
  output logic [15:0] mem_rd_word,
  input wire logic [15:0] mem_wr_word_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [1:0] mem_wr_strobe,
  input wire logic window_rd_req,
  input wire logic [14:0] window_rd_addr,
  output logic [15:0] window_rd_word
);
  logic [15:0] ram [4096]; // 8K bytes held as words
  logic [15:0] wpat; // Window word pattern
  ////////////////////////////////////////////////////////////////////////////
  // Known fill so the bench can predict every read
  initial begin
    for (int i = 0; i < 4096; i++) begin
      ram[i] = 16'(i) ^ 16'h9c63;
    end
  end
  // Top byte carries junk: it must never reach an instruction
  assign prog_rdata = {8'ha5, prog_addr ^ 24'h3c3c3c};
  assign mem_rd_word = ram[mem_rd_word_addr[12:1]];
  assign wpat = {1'b0, window_rd_addr} ^ 16'h7e81;
  // Idle window shows inverted data, never the last value
  assign window_rd_word = window_rd_req ? wpat : ~wpat;
  ////////////////////////////////////////////////////////////////////////////
  // Each lane writes only under its own strobe
  always @(posedge clock) begin
    if (mem_wr_strobe[0]) begin
      ram[mem_wr_word_addr[12:1]][7:0] <= mem_wdata[7:0];
    end
    if (mem_wr_strobe[1]) begin
      ram[mem_wr_word_addr[12:1]][15:8] <= mem_wdata[15:8];
    end
  end
endmodule : mem_array_model
`default_nettype wire

// ---- testbench/memory_space_address_decode_tb.sv ----
// Self-checking bench for the memory space address decode block
`timescale 1ns/100ps
`default_nettype none
module memory_space_address_decode_tb;
  logic clock, rst, pc_advance, pc_load, prog_fetch_vector, cfg_busy;
  logic [23:0] pc_load_addr, prog_addr, prog_instr, cfg_word1, cfg_word2;
  logic [31:0] prog_rdata;
  logic [15:0] cpu_ctrl, sfr_present_map, rd_addr, wr_addr, wr_data;
  logic [15:0] source_pointer_register, source_pointer_next, rd_data;
  logic [15:0] mem_rd_word_addr, mem_rd_word, mem_wr_word_addr, mem_wdata;
  logic [15:0] window_rd_word, wreg_old, wreg_src, wreg_new;
  logic rd_valid, rd_is_byte, rd_direct, rd_direct_near, wr_valid, wr_is_byte;
  logic post_inc_is_byte, window_rd_req, wreg_byte_load, sign_extend_op;
  logic zero_extend_op, addr_error_trap, addr_error_is_write;
  logic [12:0] rd_near_field;
  logic [1:0] mem_wr_strobe;
  logic [14:0] window_rd_addr;
  int miscompares = 0; // Mismatch count
  int tests_run = 0; // Comparison count
  memory_space_address_decode i_dut (.clock, .rst, .pc_advance, .pc_load,
    .pc_load_addr, .prog_addr, .prog_fetch_vector, .prog_rdata, .prog_instr,
    .cfg_busy, .cfg_word1, .cfg_word2, .cpu_ctrl, .sfr_present_map,
    .rd_valid, .rd_is_byte, .rd_addr, .rd_direct, .rd_direct_near,
    .rd_near_field, .wr_valid, .wr_is_byte, .wr_addr, .wr_data,
    .source_pointer_register, .post_inc_is_byte, .source_pointer_next,
    .mem_rd_word_addr, .mem_rd_word, .mem_wr_word_addr, .mem_wdata,
    .mem_wr_strobe, .window_rd_req, .window_rd_addr, .window_rd_word,
    .rd_data, .wreg_old, .wreg_src, .wreg_byte_load, .sign_extend_op,
    .zero_extend_op, .wreg_new, .addr_error_trap, .addr_error_is_write);
  mem_array_model i_mem (.clock, .prog_addr, .prog_rdata, .mem_rd_word_addr,
    .mem_rd_word, .mem_wr_word_addr, .mem_wdata, .mem_wr_strobe,
    .window_rd_req, .window_rd_addr, .window_rd_word);
  ////////////////////////////////////////////////////////////////////////////
  // Expected word from the array's known fill
  function automatic logic [15:0] wd(input logic [15:0] a);
    return {4'h0, a[12:1]} ^ 16'h9c63;
  endfunction : wd
  // Expected byte, always on the low lane
  function automatic logic [15:0] by(input logic [15:0] a);
    logic [15:0] w;
    w = wd(a);
    return {8'h00, a[0] ? w[15:8] : w[7:0]};
  endfunction : by
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One read request, data judged one cycle on
  task automatic rd(input logic [15:0] a, input logic b, input logic nr,
                    input logic [15:0] exp);
    @(posedge clock);
    rd_valid <= 1'b1;
    rd_is_byte <= b;
    rd_direct_near <= nr;
    rd_near_field <= a[12:0];
    rd_addr <= nr ? 16'hffff : a; // Junk proves the field is used
    @(posedge clock);
    rd_valid <= 1'b0;
    #1;
    check(rd_data, exp);
  endtask : rd
  // One write request, lanes judged at once, trap one cycle on
  task automatic wr(input logic [15:0] a, input logic b, input logic [15:0] d,
                    input logic [1:0] st, input logic [15:0] dx);
    @(posedge clock);
    wr_valid <= 1'b1;
    wr_is_byte <= b;
    wr_addr <= a;
    wr_data <= d;
    #1;
    check(mem_wr_strobe, st);
    if (st != 2'b00) begin
      check(mem_wdata, dx);
    end
    @(posedge clock);
    wr_valid <= 1'b0;
    #1;
    check(addr_error_trap, st == 2'b00);
    check(addr_error_is_write, st == 2'b00);
    @(posedge clock);
    #1;
    check(addr_error_trap, 1'b0);
  endtask : wr
  ////////////////////////////////////////////////////////////////////////////
  // Configuration copy and reset start point
  task automatic t_reset;
    for (int n = 0; n < 8 && prog_addr !== 24'h00abfc; n++) begin
      @(posedge clock);
      #1;
    end
    check(prog_addr, 24'h00abfc);
    @(posedge clock);
    #1;
    check(prog_addr, 24'h00abfe);
    @(posedge clock);
    #1;
    check(prog_addr, 24'h000000);
    check(cfg_busy, 1'b0);
    check(prog_fetch_vector, 1'b1);
    check(cfg_word1, 24'h00abfc ^ 24'h3c3c3c);
    check(cfg_word2, 24'h00abfe ^ 24'h3c3c3c);
    $display("reset test done");
  endtask : t_reset
  // Program counter steps, loads and vector area edge
  task automatic t_program;
    @(posedge clock);
    pc_advance <= 1'b1;
    repeat (2) @(posedge clock);
    pc_advance <= 1'b0;
    #1;
    check(prog_addr, 24'h000004);
    @(posedge clock);
    #1;
    check(prog_instr, 24'h000004 ^ 24'h3c3c3c);
    @(posedge clock);
    pc_load <= 1'b1;
    pc_load_addr <= 24'h0001ff;
    @(posedge clock);
    pc_load <= 1'b0;
    #1;
    check(prog_addr, 24'h0001fe);
    check(prog_fetch_vector, 1'b1);
    @(posedge clock);
    pc_advance <= 1'b1;
    @(posedge clock);
    pc_advance <= 1'b0;
    #1;
    check(prog_addr, 24'h000200);
    check(prog_fetch_vector, 1'b0);
    $display("program test done");
  endtask : t_program
  // Data reads across the map
  task automatic t_reads;
    rd(16'h0ffe, 1'b0, 1'b0, wd(16'h0ffe));
    rd(16'h0ffe, 1'b1, 1'b0, by(16'h0ffe));
    rd(16'h0fff, 1'b1, 1'b0, by(16'h0fff));
    rd(16'h1ffe, 1'b0, 1'b1, wd(16'h1ffe));
    rd(16'h2000, 1'b0, 1'b0, 16'h0000);
    rd(16'h7fff, 1'b1, 1'b0, 16'h0000);
    rd(16'h0400, 1'b0, 1'b0, 16'h0000);
    rd(16'h0380, 1'b0, 1'b0, wd(16'h0380));
    rd(16'h8010, 1'b0, 1'b0, 16'h0000);
    @(posedge clock);
    cpu_ctrl <= 16'h0004;
    rd(16'h8010, 1'b0, 1'b0, 16'h0010 ^ 16'h7e81);
    $display("read test done");
  endtask : t_reads
  // Lane strobes, suppressed write and read back
  task automatic t_writes;
    wr(16'h0100, 1'b0, 16'hbeef, 2'b11, 16'hbeef);
    wr(16'h0101, 1'b1, 16'h0042, 2'b10, 16'h4242);
    wr(16'h0100, 1'b1, 16'h0011, 2'b01, 16'h1111);
    rd(16'h0100, 1'b0, 1'b0, 16'h4211);
    wr(16'h0103, 1'b0, 16'h5555, 2'b00, 16'h0000);
    check(addr_error_is_write, 1'b0);
    rd(16'h0102, 1'b0, 1'b0, wd(16'h0102));
    $display("write test done");
  endtask : t_writes
  // Odd word read beside an aligned write in the same cycle
  task automatic t_trap;
    @(posedge clock);
    rd_valid <= 1'b1;
    rd_is_byte <= 1'b0;
    rd_direct_near <= 1'b0;
    rd_addr <= 16'h0105;
    wr_valid <= 1'b1;
    wr_is_byte <= 1'b1;
    wr_addr <= 16'h0200;
    wr_data <= 16'h0077;
    #1;
    check(mem_rd_word_addr, 16'h0104);
    check(mem_wr_word_addr, 16'h0200);
    check(mem_wr_strobe, 2'b01);
    @(posedge clock);
    rd_valid <= 1'b0;
    wr_valid <= 1'b0;
    #1;
    check(addr_error_trap, 1'b1);
    check(addr_error_is_write, 1'b0);
    @(posedge clock);
    #1;
    check(addr_error_trap, 1'b0);
    $display("trap test done");
  endtask : t_trap
  // Pointer step and register extension
  task automatic t_alu;
    @(posedge clock);
    source_pointer_register <= 16'hfffe;
    post_inc_is_byte <= 1'b1;
    wreg_src <= 16'h5680;
    wreg_byte_load <= 1'b1;
    #1;
    check(source_pointer_next, 16'hffff);
    check(wreg_new, 16'h1280);
    @(posedge clock);
    post_inc_is_byte <= 1'b0;
    sign_extend_op <= 1'b1;
    #1;
    check(source_pointer_next, 16'h0000);
    check(wreg_new, 16'hff80);
    @(posedge clock);
    sign_extend_op <= 1'b0;
    zero_extend_op <= 1'b1;
    wreg_src <= 16'hff7f;
    #1;
    check(wreg_new, 16'h007f);
    $display("extension test done");
  endtask : t_alu
  // Counts, verdict, end of run
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////
  // 25 ns clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Run is about 60 cycles; this limit cuts a hang
  initial begin
    repeat (3000) @(posedge clock);
    miscompares++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    {rst, pc_advance, pc_load, rd_valid, rd_is_byte, rd_direct_near} = 6'h20;
    {wr_valid, wr_is_byte, post_inc_is_byte, wreg_byte_load} = 4'h0;
    {sign_extend_op, zero_extend_op} = 2'h0;
    rd_direct = 1'b1;
    pc_load_addr = 24'h000000;
    {cpu_ctrl, rd_addr, wr_addr, wr_data} = 64'h0;
    sfr_present_map = 16'h00ff; // Blocks 0-7 present, upper half holes
    rd_near_field = 13'h0000;
    {source_pointer_register, wreg_src} = 32'h0;
    wreg_old = 16'h1234;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_program();
    t_reads();
    t_writes();
    t_trap();
    t_alu();
    tally_and_finish();
  end
endmodule : memory_space_address_decode_tb
`default_nettype wire
